/* File: src/qdsr_core.sv */
// device side of a quad-port ddr static memory with burst of two
// assumes: input_timing_pos/neg are synchronous inputs, much slower than mclk
`timescale 1ns/10ps
module qdsr_core #(
  parameter int DATA_W  = qdsr_pkg::DATA_W_DEF,
  parameter int BADDR_W = qdsr_pkg::BADDR_W_DEF
) (
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  input  wire logic                          input_timing_pos,
  input  wire logic                          input_timing_neg,
  input  wire logic                          rd_sel_n,
  input  wire logic                          wr_sel_n,
  input  wire logic                          dll_off_n,
  input  wire logic [BADDR_W-1:0]            addr_in,
  input  wire logic [DATA_W-1:0]             data_in,
  input  wire logic [DATA_W/qdsr_pkg::LANE_W-1:0] byte_lane_strobe_n,
  output logic      [DATA_W-1:0]             data_out,
  output logic                               echo_timing_pos,
  output logic                               echo_timing_neg,
  output logic                               read_valid_flag
);
  localparam int LANES = DATA_W / qdsr_pkg::LANE_W;
  localparam int PD    = qdsr_pkg::PIPE_DEPTH;

  logic               pos_q_reg;
  logic               neg_q_reg;
  logic               dll_on_reg;
  logic               wr_pend_reg;
  logic [DATA_W-1:0]  wd0_reg;
  logic [DATA_W-1:0]  wm0_reg;
  logic               wbuf_valid_reg;
  logic [BADDR_W-1:0] wbuf_addr_reg;
  logic [DATA_W-1:0]  wbuf_d0_reg;
  logic [DATA_W-1:0]  wbuf_d1_reg;
  logic [DATA_W-1:0]  wbuf_m0_reg;
  logic [DATA_W-1:0]  wbuf_m1_reg;
  logic               pipe_v_reg  [PD];
  logic [DATA_W-1:0]  pipe_w0_reg [PD];
  logic [DATA_W-1:0]  pipe_w1_reg [PD];
  logic [DATA_W-1:0]  data_out_reg;
  logic               echo_reg;
  logic               echo_n_reg;
  logic               valid_reg;
  logic [DATA_W-1:0]  arr_w0;
  logic [DATA_W-1:0]  arr_w1;
  logic [DATA_W-1:0]  lane_mask;
  logic [DATA_W-1:0]  fwd_w0;
  logic [DATA_W-1:0]  fwd_w1;
  logic               pos_rise;
  logic               neg_rise;
  logic               rd_take;
  logic               wr_take;
  logic               fwd_hit;

  // edge events of the timing pair
  assign pos_rise = input_timing_pos & ~pos_q_reg;
  assign neg_rise = input_timing_neg & ~neg_q_reg;
  assign rd_take  = pos_rise & ~rd_sel_n;
  assign wr_take  = pos_rise & ~wr_sel_n;

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign lane_mask[gl*qdsr_pkg::LANE_W +: qdsr_pkg::LANE_W] =
        {qdsr_pkg::LANE_W{~byte_lane_strobe_n[gl]}};
    end
  endgenerate

  assign fwd_hit = wbuf_valid_reg & (wbuf_addr_reg == addr_in);
  assign fwd_w0  = fwd_hit ? ((wbuf_d0_reg & wbuf_m0_reg) | (arr_w0 & ~wbuf_m0_reg)) : arr_w0;
  assign fwd_w1  = fwd_hit ? ((wbuf_d1_reg & wbuf_m1_reg) | (arr_w1 & ~wbuf_m1_reg)) : arr_w1;

  assign data_out        = data_out_reg;
  assign echo_timing_pos = echo_reg;
  assign echo_timing_neg = echo_n_reg;
  assign read_valid_flag = valid_reg;

  qdsr_array #(
    .DATA_W  (DATA_W),
    .BADDR_W (BADDR_W)
  ) u_array (
    .mclk     (mclk),
    .wr_en    (wbuf_valid_reg),
    .wr_addr  (wbuf_addr_reg),
    .wr_word0 (wbuf_d0_reg),
    .wr_word1 (wbuf_d1_reg),
    .wr_mask0 (wbuf_m0_reg),
    .wr_mask1 (wbuf_m1_reg),
    .rd_addr  (addr_in),
    .rd_word0 (arr_w0),
    .rd_word1 (arr_w1)
  );

  // edge history and loop mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q_reg  <= 1'b0;
      neg_q_reg  <= 1'b0;
      dll_on_reg <= 1'b0;
    end else begin
      pos_q_reg  <= input_timing_pos;
      neg_q_reg  <= input_timing_neg;
      dll_on_reg <= dll_off_n;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      wd0_reg     <= '0;
      wm0_reg     <= '0;
    end else if (pos_rise) begin
      wr_pend_reg <= wr_take;
      wd0_reg     <= data_in;
      wm0_reg     <= lane_mask;
    end else if (neg_rise) begin
      wr_pend_reg <= 1'b0;
    end
  end

  // address and second word complete the buffered write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wbuf_valid_reg <= 1'b0;
      wbuf_addr_reg  <= '0;
      wbuf_d0_reg    <= '0;
      wbuf_d1_reg    <= '0;
      wbuf_m0_reg    <= '0;
      wbuf_m1_reg    <= '0;
    end else begin
      wbuf_valid_reg <= neg_rise & wr_pend_reg;
      if (neg_rise & wr_pend_reg) begin
        wbuf_addr_reg <= addr_in;
        wbuf_d0_reg   <= wd0_reg;
        wbuf_d1_reg   <= data_in;
        wbuf_m0_reg   <= wm0_reg;
        wbuf_m1_reg   <= lane_mask;
      end
    end
  end

  // read pipeline steps once per pos edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < PD; i++) begin
        pipe_v_reg[i]  <= 1'b0;
        pipe_w0_reg[i] <= '0;
        pipe_w1_reg[i] <= '0;
      end
    end else if (pos_rise) begin
      pipe_v_reg[0]  <= rd_take;
      pipe_w0_reg[0] <= fwd_w0;
      pipe_w1_reg[0] <= fwd_w1;
      for (int i = 1; i < PD; i++) begin
        pipe_v_reg[i]  <= pipe_v_reg[i-1];
        pipe_w0_reg[i] <= pipe_w0_reg[i-1];
        pipe_w1_reg[i] <= pipe_w1_reg[i-1];
      end
    end
  end

  // outputs move on timing edges only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out_reg <= '0;
      valid_reg    <= 1'b0;
      echo_reg     <= 1'b0;
      echo_n_reg   <= 1'b1;
    end else if (neg_rise) begin
      echo_reg   <= 1'b0;
      echo_n_reg <= 1'b1;
      if (dll_on_reg) begin
        // first word on third neg edge
        data_out_reg <= pipe_w0_reg[qdsr_pkg::STAGE_SLOW];
        valid_reg    <= pipe_v_reg[qdsr_pkg::STAGE_SLOW];
      end else begin
        data_out_reg <= pipe_w1_reg[qdsr_pkg::STAGE_FAST2];
        valid_reg    <= pipe_v_reg[qdsr_pkg::STAGE_FAST2];
      end
    end else if (pos_rise) begin
      echo_reg   <= 1'b1;
      echo_n_reg <= 1'b0;
      if (dll_on_reg) begin
        // second word on third pos edge
        data_out_reg <= pipe_w1_reg[qdsr_pkg::STAGE_SLOW];
        valid_reg    <= pipe_v_reg[qdsr_pkg::STAGE_SLOW];
      end else begin
        data_out_reg <= pipe_w0_reg[qdsr_pkg::STAGE_FAST];
        valid_reg    <= pipe_v_reg[qdsr_pkg::STAGE_FAST];
      end
    end
  end

  // helper: history of read commands per pos edge
  logic [PD-1:0] rd_hist_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_hist_reg <= '0;
    end else if (pos_rise) begin
      rd_hist_reg <= {rd_hist_reg[PD-2:0], ~rd_sel_n};
    end
  end

  a_echo_rise: assert property (@(posedge mclk) disable iff (!arst_n)
    pos_rise && !neg_rise |=> echo_timing_pos && !echo_timing_neg)
    else $error("echo clock did not rise with the pos edge");
  a_echo_pair: assert property (@(posedge mclk) disable iff (!arst_n)
    echo_timing_pos != echo_timing_neg)
    else $error("echo clocks not complementary");
  a_rd_lat_slow: assert property (@(posedge mclk) disable iff (!arst_n)
    neg_rise && !pos_rise && dll_on_reg |=>
      read_valid_flag == $past(rd_hist_reg[qdsr_pkg::STAGE_SLOW]))
    else $error("first read word not 2.5 cycles after command");
  a_rd_second: assert property (@(posedge mclk) disable iff (!arst_n)
    pos_rise && !neg_rise && dll_on_reg |=>
      read_valid_flag == $past(rd_hist_reg[qdsr_pkg::STAGE_SLOW]))
    else $error("second read word not on third pos edge");
  a_rd_lat_fast: assert property (@(posedge mclk) disable iff (!arst_n)
    pos_rise && !neg_rise && !dll_on_reg |=>
      read_valid_flag == $past(rd_hist_reg[qdsr_pkg::STAGE_FAST]))
    else $error("bypass read latency not one cycle");
  a_out_steady: assert property (@(posedge mclk) disable iff (!arst_n)
    !pos_rise && !neg_rise |=> $stable(data_out) && $stable(read_valid_flag))
    else $error("outputs moved between timing edges");
  a_wr_commit: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_pend_reg && neg_rise |=> wbuf_valid_reg && wbuf_addr_reg == $past(addr_in))
    else $error("buffered write not completed at neg edge");
  a_wr_pending: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_take |=> wr_pend_reg)
    else $error("write command not held until its neg edge");
  a_wr_source: assert property (@(posedge mclk) disable iff (!arst_n)
    wbuf_valid_reg |-> $past(neg_rise) && $past(wr_pend_reg))
    else $error("array write without neg edge and pending command");
  a_rd_start: assert property (@(posedge mclk) disable iff (!arst_n)
    pos_rise |=> pipe_v_reg[0] == $past(!rd_sel_n))
    else $error("read command not registered at pos edge");

  c_read_slow: cover property (@(posedge mclk) disable iff (!arst_n)
    rd_take && dll_on_reg);
  c_read_fast: cover property (@(posedge mclk) disable iff (!arst_n)
    rd_take && !dll_on_reg);
  c_rd_wr_same: cover property (@(posedge mclk) disable iff (!arst_n)
    rd_take && wr_take);
  c_fwd_hit: cover property (@(posedge mclk) disable iff (!arst_n)
    pos_rise && fwd_hit);
endmodule // qdsr_core

/* File: src/qdsr_pkg.sv */
// constants shared by the quad-port ddr static memory interface logic
// assumes: one system clock; the timing clock pair arrives as synchronous inputs
// Summary of operation
// - organised as 1M x 36 or 2M x 18, data width set to match
// - read and write ports are separate and usable in the same period
// - every read and write moves exactly two words, one per half period
// - a rising input_timing_pos edge starts any operation; later timing pair edges complete it
// - read and write addresses taken on alternating clock edges
// - input_timing_pos rise samples read address, both selects, first write word
// - input_timing_neg rise samples write address, lane strobes, second write word
// - lane strobes travel with each word; a high strobe blocks that byte
// - write buffer holds early write data until its address arrives
// - first read word leaves on third neg edge after command: 2.5 cycles
// - second read word leaves on third pos edge after the command
// - outputs change only on rising edges of the input timing pair
// - echo clock pair drives edges aligned with read data transitions
// - read_valid_flag marks valid read words, aligned with the echo clocks
// - wr_sel_n low at a pos edge starts a write; its address is registered at the next neg edge
// - rd_sel_n low at a pos edge registers address and starts a read
// - dll_off_n low bypasses the loop and cuts read latency to one cycle
package qdsr_pkg;
  localparam int DATA_W_DEF  = 36;  // 1M x 36 organisation
  localparam int BADDR_W_DEF = 19;  // burst address, two words each
  localparam int LANE_W      = 9;   // bits governed by one strobe
  localparam int BURST_LEN   = 2;   // fixed burst
  localparam int PIPE_DEPTH  = 3;   // read stages, one per pos edge
  localparam int STAGE_SLOW  = 2;   // stage read out with the loop running
  localparam int STAGE_FAST  = 0;   // first-word stage with the loop bypassed
  localparam int STAGE_FAST2 = 1;   // second-word stage with the loop bypassed
endpackage

/* File: src/qdsr_array.sv */
// flip-flop storage of the memory: one burst write port, one burst read port
// assumes: write data arrives as two words with per-bit write masks
`timescale 1ns/10ps
module qdsr_array #(
  parameter int DATA_W  = qdsr_pkg::DATA_W_DEF,
  parameter int BADDR_W = qdsr_pkg::BADDR_W_DEF
) (
  input  wire logic               mclk,
  input  wire logic               wr_en,
  input  wire logic [BADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0]  wr_word0,
  input  wire logic [DATA_W-1:0]  wr_word1,
  input  wire logic [DATA_W-1:0]  wr_mask0,
  input  wire logic [DATA_W-1:0]  wr_mask1,
  input  wire logic [BADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0]  rd_word0,
  output logic      [DATA_W-1:0]  rd_word1
);
  logic [DATA_W-1:0] mem_reg [2**(BADDR_W+1)];

  // both words of a burst read at once
  assign rd_word0 = mem_reg[{rd_addr, 1'b0}];
  assign rd_word1 = mem_reg[{rd_addr, 1'b1}];

  // masked burst write; storage has no reset
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_reg[{wr_addr, 1'b0}] <= (wr_word0 & wr_mask0) | (mem_reg[{wr_addr, 1'b0}] & ~wr_mask0);
      mem_reg[{wr_addr, 1'b1}] <= (wr_word1 & wr_mask1) | (mem_reg[{wr_addr, 1'b1}] & ~wr_mask1);
    end
  end
endmodule // qdsr_array

/* File: test/qdsr_ctrl_model.sv */
// controller model: makes the timing clock pair and drives one command slot per call
// assumes: clock pair stands still between calls; HALF mclk cycles per half period
`timescale 1ns/10ps
module qdsr_ctrl_model #(
  parameter int DATA_W  = 36,
  parameter int BADDR_W = 4,
  parameter int HALF    = 4
) (
  input  wire logic                               mclk,
  output logic                                    input_timing_pos,
  output logic                                    input_timing_neg,
  output logic                                    rd_sel_n,
  output logic                                    wr_sel_n,
  output logic [BADDR_W-1:0]                      addr_in,
  output logic [DATA_W-1:0]                       data_in,
  output logic [DATA_W/qdsr_pkg::LANE_W-1:0]      byte_lane_strobe_n
);
  // idle levels at time zero, clock pair low
  initial begin
    {input_timing_pos, input_timing_neg, addr_in, data_in} = '0;
    {rd_sel_n, wr_sel_n, byte_lane_strobe_n} = '1;
  end
  // one clock period: pos half carries command, neg half the write address
  task automatic slot(input logic rd, input logic [BADDR_W-1:0] ra, input logic wr,
                      input logic [BADDR_W-1:0] wa, input logic [DATA_W-1:0] d0,
                      input logic [DATA_W-1:0] d1, input logic [DATA_W/9-1:0] s0,
                      input logic [DATA_W/9-1:0] s1);
    @(posedge mclk);
    #1;
    {input_timing_pos, input_timing_neg, rd_sel_n, wr_sel_n} = {2'b10, ~rd, ~wr};
    {addr_in, data_in, byte_lane_strobe_n} = {ra, d0, s0};
    repeat (HALF) @(posedge mclk);
    #1;
    {input_timing_pos, input_timing_neg, rd_sel_n, wr_sel_n} = 4'b0111;
    {addr_in, data_in, byte_lane_strobe_n} = {wa, d1, s1};
    repeat (HALF - 1) @(posedge mclk);
    #1;
    addr_in = ~addr_in;  // released lines show no stale value
    data_in = ~data_in;
  endtask
endmodule // qdsr_ctrl_model

/* File: test/tb_quad_port_ddr_sram_burst2.sv */
// self-checking bench of the memory interface, driven through the controller model
// assumes: half period of 4 mclk; small address width keeps the array short
`timescale 1ns/10ps
module tb_quad_port_ddr_sram_burst2;
  localparam int DW = 36;
  localparam int AW = 4;
  localparam int NL = DW / qdsr_pkg::LANE_W;
  logic          mclk, arst_n, dll_off_n, prev_echo;
  logic          k_pos, k_neg, rd_n, wr_n, echo_pos, echo_neg, valid;
  logic [AW-1:0] addr;
  logic [DW-1:0] din, dout;
  logic [NL-1:0] strobe_n;
  logic [31:0]   seed;
  logic [DW-1:0] mem [2**(AW+1)];
  logic [DW:0]   exp_d [$];
  int            exp_c [$];
  int            cyc, n_errors, n_checks;

  qdsr_ctrl_model #(.DATA_W(DW), .BADDR_W(AW)) ctrl_u (.mclk(mclk),
    .input_timing_pos(k_pos), .input_timing_neg(k_neg), .rd_sel_n(rd_n), .wr_sel_n(wr_n),
    .addr_in(addr), .data_in(din), .byte_lane_strobe_n(strobe_n));
  qdsr_core #(.DATA_W(DW), .BADDR_W(AW)) dut_u (.mclk(mclk), .arst_n(arst_n),
    .input_timing_pos(k_pos), .input_timing_neg(k_neg), .rd_sel_n(rd_n), .wr_sel_n(wr_n),
    .dll_off_n(dll_off_n), .addr_in(addr), .data_in(din), .byte_lane_strobe_n(strobe_n),
    .data_out(dout), .echo_timing_pos(echo_pos), .echo_timing_neg(echo_neg),
    .read_valid_flag(valid));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // lanes with strobe low take new byte
  function automatic logic [DW-1:0] merge(logic [DW-1:0] o, logic [DW-1:0] n, logic [NL-1:0] s);
    for (int i = 0; i < NL; i++) if (!s[i]) o[9*i +: 9] = n[9*i +: 9];
    return o;
  endfunction

  // one slot: note expected read words and their cycles, then drive it
  task automatic op(input logic rd, input logic [AW-1:0] ra, input logic wr,
                    input logic [AW-1:0] wa, input logic [NL-1:0] s0, input logic [NL-1:0] s1);
    logic [DW-1:0] d0, d1;
    d0 = DW'({rnd(), rnd()});
    d1 = DW'({rnd(), rnd()});
    if (rd) begin
      exp_d.push_back({~dll_off_n, mem[{ra, 1'b0}]});
      // pos edge at cyc+2, eight mclk per period: 2.5 or 1 period to word0
      exp_c.push_back(dll_off_n ? cyc + 22 : cyc + 10);
      exp_d.push_back({dll_off_n, mem[{ra, 1'b1}]});
      exp_c.push_back(dll_off_n ? cyc + 26 : cyc + 14);
    end
    if (wr) begin
      mem[{wa, 1'b0}] = merge(mem[{wa, 1'b0}], d0, s0);
      mem[{wa, 1'b1}] = merge(mem[{wa, 1'b1}], d1, s1);
    end
    ctrl_u.slot(rd, ra, wr, wa, d0, d1, s0, s1);
  endtask

  // idle slots until every noted word came out, bounded
  task automatic drain;
    for (int k = 0; k < 8 && exp_d.size() > 0; k++) op(0, 0, 0, 0, '1, '1);
    op(0, 0, 0, 0, '1, '1);
    chk(64'(exp_d.size()), 0);
    chk(valid, 0);
  endtask

  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  // watcher: each echo change while valid is one read word
  always @(negedge mclk) begin
    if (arst_n && echo_pos !== prev_echo && valid === 1'b1) begin
      if (exp_d.size() == 0) begin
        chk(valid, 1'b0);
      end else begin
        chk({echo_pos, dout}, exp_d.pop_front());
        chk(cyc, exp_c.pop_front());
        chk(echo_neg ^ echo_pos, 64'h1);
      end
    end
    prev_echo = echo_pos;
  end

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial begin : main
    logic [31:0] r;
    logic [AW-1:0] wa;
    {arst_n, dll_off_n, prev_echo, cyc, n_errors, n_checks, seed} = {3'b010, 96'h0, 32'h19};
    repeat (3) @(posedge mclk);
    #1;
    chk({valid, echo_pos, echo_neg, dout}, {3'b001, 36'h0});
    arst_n = 1;
    // concurrent read of last slot's write
    for (int i = 0; i < 16; i++) op(i > 0, AW'(i - 1), 1, AW'(i), '0, '0);
    for (int i = 0; i < 16; i++) op(0, 0, 1, AW'(i), NL'(i), ~NL'(i));
    for (int i = 0; i < 16; i++) op(1, AW'(i), 0, 0, '1, '1);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      wa = (r[9:6] == r[4:1]) ? r[4:1] + 1'b1 : r[9:6];
      op(r[0], r[4:1], r[5], wa, r[13:10], r[17:14]);
    end
    drain();
    dll_off_n = 0;
    op(0, 0, 0, 0, '1, '1);
    op(0, 0, 0, 0, '1, '1);
    // short latency with the loop bypassed
    for (int i = 0; i < 6; i++) op(1, AW'(3 * i), i[0], AW'(3 * i + 1), '0, 4'ha);
    drain();
    end_of_test();
  end
endmodule // tb_quad_port_ddr_sram_burst2
